// ---- shared/sslwp_map.svh ----
// Constants for the synchronous late-write SRAM port
`ifndef SSLWP_MAP_SVH
`define SSLWP_MAP_SVH
`define SSLWP_LANES     4
`define SSLWP_LANE_W    9
`define SSLWP_DQ_W      36
`define SSLWP_ADDR_W    8
`define SSLWP_HI_W      6
`define SSLWP_DEPTH     256
`define SSLWP_BURST_W   2
`define SSLWP_BURST_0   2'h0
`define SSLWP_BURST_1   2'h1
`define SSLWP_SLEEP_CYC 2'h2
`define SSLWP_CNT_0     2'h0
`define SSLWP_CNT_1     2'h1
`define SSLWP_SYNC_W    4
`define SSLWP_SY_G      3
`define SSLWP_SY_ZZ     2
`define SSLWP_SY_FT     1
`define SSLWP_SY_LBO    0
// Output enable off, awake, pipelined, linear order
`define SSLWP_SYNC_RST  4'hA
`endif

// ---- shared/sslwp_pkg.sv ----
// Types shared by the SRAM port logic
`include "sslwp_map.svh"
package sslwp_pkg;
  // Operation of the current burst
  typedef enum logic [1:0] {OP_IDLE, OP_RD, OP_WR} sslwp_op_t;
  // One registered command
  typedef struct packed {
    logic                       valid;
    logic                       wr;
    logic [`SSLWP_LANES-1:0]    be;
    logic [`SSLWP_ADDR_W-1:0]   addr;
  } sslwp_cmd_t;
endpackage : sslwp_pkg

// ---- core/sslwp_core.sv ----
// Synchronous late-write SRAM port with burst counter, sleep and byte lanes
// How it works
// [RQ1] Gate high holds every internal state; sleep, synchronisers and driver enable still advance
// [RQ2] Sample inputs on edge; G, order, sleep async
// [RQ3] Controller loads address with advance_load low
// [RQ4] Selected only when all three selects active
// [RQ5] Read begins: gate, select, write high, load
// [RQ6] Pipelined read data two cycles after command
// [RQ7] Pipelined write data taken at third edge
// [RQ8] Write when selected, gated on, strobe low
// [RQ9] Each byte strobe enables its 9-bit lane
// [RQ10] Write with no lanes is a no-op
// [RQ11] Flow-through read data one cycle sooner
// [RQ12] Flow-through write data taken at second edge
// [RQ13] Read to write needs no dead cycles
// [RQ14] Output enable forces drivers off anytime
// [RQ15] Low address bits preload burst counter
// [RQ16] Flow mode pin low selects flow-through
// [RQ17] Linear order pin held static by board
// [RQ18] Sleep request acts independent of edge sampling
// [RQ19] Advance high uses counter-generated address
// [RQ20] Two-bit counter, linear add or interleave xor
// [RQ21] Sleep entered and left after two cycles
// [RQ22] Drivers off during write cycles
`timescale 1ns/10ps
`default_nettype none
`include "sslwp_map.svh"
module sslwp_core
  import sslwp_pkg::*;
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      sys_rst_i,
  input  wire logic [`SSLWP_HI_W-1:0]    addr_i,
  input  wire logic [`SSLWP_BURST_W-1:0] burst_start_bits_i,
  input  wire logic                      clk_gate_n_i,
  input  wire logic                      advance_load_i,
  input  wire logic                      write_n_i,
  input  wire logic                      chip_sel_lo_a_n_i,
  input  wire logic                      chip_sel_hi_i,
  input  wire logic                      chip_sel_lo_b_n_i,
  input  wire logic                      lane_a_strobe_n_i,
  input  wire logic                      lane_b_strobe_n_i,
  input  wire logic                      lane_c_strobe_n_i,
  input  wire logic                      lane_d_strobe_n_i,
  input  wire logic                      out_en_n_i,
  input  wire logic                      sleep_request_i,
  input  wire logic                      flow_mode_n_i,
  input  wire logic                      linear_order_n_i,
  input  wire logic [`SSLWP_DQ_W-1:0]    dq_i,
  output logic      [`SSLWP_DQ_W-1:0]    dq_o,
  output logic                           dq_oe_o,
  output logic                           asleep_o
);

  // Two-stage synchronisers for the asynchronous and static pins
  logic [`SSLWP_SYNC_W-1:0] sy1_q, sy1_d;   // First stage, read only by sy2
  logic [`SSLWP_SYNC_W-1:0] sy2_q, sy2_d;   // Second stage, safe to use
  logic                     g_off;          // Output enable deasserted
  logic                     zz_on;          // Sleep requested
  logic                     pipe_mode;      // Pipelined when flow pin high
  logic                     lin_order;      // Linear burst order

  // Next value of the synchronisers
  always_comb begin
    sy1_d = {out_en_n_i, sleep_request_i, flow_mode_n_i, linear_order_n_i};  // [RQ2]
    sy2_d = sy1_q;
  end

  // Synchroniser registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sy1_q <= `SSLWP_SYNC_RST;
      sy2_q <= `SSLWP_SYNC_RST;
    end else begin
      sy1_q <= sy1_d;
      sy2_q <= sy2_d;
    end
  end

  assign g_off     = sy2_q[`SSLWP_SY_G];
  assign zz_on     = sy2_q[`SSLWP_SY_ZZ];
  assign pipe_mode = sy2_q[`SSLWP_SY_FT];      // [RQ16]
  assign lin_order = ~sy2_q[`SSLWP_SY_LBO];    // [RQ17]

  // Sleep state: follows the request after a fixed delay
  logic       asleep_q, asleep_d;   // Powered down, state kept
  logic [1:0] slp_cnt_q, slp_cnt_d; // Cycles the request has differed

  // Next sleep state
  always_comb begin
    asleep_d  = asleep_q;
    slp_cnt_d = `SSLWP_CNT_0;
    if (zz_on != asleep_q) begin                          // [RQ18]
      if (slp_cnt_q == `SSLWP_SLEEP_CYC - `SSLWP_CNT_1) begin
        asleep_d = zz_on;                                 // [RQ21]
      end else begin
        slp_cnt_d = slp_cnt_q + `SSLWP_CNT_1;
      end
    end
  end

  // Sleep registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      asleep_q  <= 1'b0;
      slp_cnt_q <= `SSLWP_CNT_0;
    end else begin
      asleep_q  <= asleep_d;
      slp_cnt_q <= slp_cnt_d;
    end
  end

  // Command decode, burst counter and pipeline stages
  logic                      run;        // Edge is not gated, not asleep
  logic                      sel;        // All three selects active
  logic                      load;       // New external address
  logic [`SSLWP_LANES-1:0]   be;         // Byte enables, active high
  sslwp_op_t                 op_q, op_d;       // Operation of the burst
  logic [`SSLWP_HI_W-1:0]    base_q, base_d;   // Upper burst address
  logic [`SSLWP_BURST_W-1:0] start_q, start_d; // Preloaded low bits
  logic [`SSLWP_BURST_W-1:0] step_q, step_d;   // Accesses into burst
  logic [`SSLWP_BURST_W-1:0] low;              // Generated low bits
  sslwp_cmd_t                cmd;              // Command of this edge
  sslwp_cmd_t                s1_q, s1_d;       // Command one edge old
  sslwp_cmd_t                s2_q, s2_d;       // Command two edges old

  assign run  = ~clk_gate_n_i & ~asleep_q;                              // [RQ1]
  assign sel  = ~chip_sel_lo_a_n_i & chip_sel_hi_i & ~chip_sel_lo_b_n_i; // [RQ4]
  assign load = ~advance_load_i;                                        // [RQ3]
  assign be   = ~{lane_d_strobe_n_i, lane_c_strobe_n_i,
                  lane_b_strobe_n_i, lane_a_strobe_n_i};

  // Next command and burst state
  always_comb begin
    op_d    = op_q;
    base_d  = base_q;
    start_d = start_q;
    step_d  = step_q;
    low     = burst_start_bits_i;
    cmd     = '0;
    if (load) begin
      // Begin: selects and write strobe pick the operation
      op_d    = sel ? (write_n_i ? OP_RD : OP_WR) : OP_IDLE;  // [RQ5] [RQ8]
      base_d  = addr_i;
      start_d = burst_start_bits_i;                          // [RQ15]
      step_d  = `SSLWP_BURST_0;
      cmd.addr = {addr_i, burst_start_bits_i};
    end else begin
      // Continue: counter makes the address, wraps after four
      step_d = step_q + `SSLWP_BURST_1;                      // [RQ19] [RQ20]
      low    = lin_order ? (start_q + step_d) : (start_q ^ step_d);
      cmd.addr = {base_q, low};
    end
    cmd.valid = (op_d != OP_IDLE);
    cmd.wr    = (op_d == OP_WR);
    cmd.be    = be;
    s1_d = s1_q;
    s2_d = s2_q;
    if (run) begin
      s1_d = cmd;
      s2_d = s1_q;
    end else begin
      // Gated or asleep: hold the burst
      op_d    = op_q;                                        // [RQ1]
      base_d  = base_q;
      start_d = start_q;
      step_d  = step_q;
    end
  end

  // Command and burst registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      op_q    <= OP_IDLE;
      base_q  <= '0;
      start_q <= `SSLWP_BURST_0;
      step_q  <= `SSLWP_BURST_0;
      s1_q    <= '0;
      s2_q    <= '0;
    end else begin
      op_q    <= op_d;
      base_q  <= base_d;
      start_q <= start_d;
      step_q  <= step_d;
      s1_q    <= s1_d;
      s2_q    <= s2_d;
    end
  end

  // Memory array and late write
  logic [`SSLWP_DQ_W-1:0] mem_q [`SSLWP_DEPTH];  // Storage words
  logic [`SSLWP_DQ_W-1:0] mem_d [`SSLWP_DEPTH];  // Next storage
  sslwp_cmd_t             wst;                   // Command owning dq_i now
  logic [`SSLWP_DQ_W-1:0] wmask;                 // Lane mask of that write

  // Flow-through takes data one edge after, pipelined two edges after
  assign wst = pipe_mode ? s2_q : s1_q;          // [RQ7] [RQ12] [RQ13]

  // One lane mask slice per byte strobe
  for (genvar ln = 0; ln < `SSLWP_LANES; ln++) begin : g_lane
    assign wmask[ln*`SSLWP_LANE_W +: `SSLWP_LANE_W] =
      {`SSLWP_LANE_W{wst.be[ln]}};               // [RQ9]
  end

  // Next memory contents
  always_comb begin
    mem_d = mem_q;
    if (run && wst.valid && wst.wr && (wst.be != '0)) begin  // [RQ8] [RQ10]
      mem_d[wst.addr] = (mem_q[wst.addr] & ~wmask) | (dq_i & wmask);
    end
  end

  // Memory registers, contents undefined until written
  always_ff @(posedge clk_sys_i) begin
    mem_q <= mem_d;
  end

  // Read data path and output drivers
  sslwp_cmd_t             rst_c;            // Command whose data is next
  logic                   rdv_q, rdv_d;     // Read data on the pins
  logic [`SSLWP_DQ_W-1:0] dq_q, dq_d;       // Output data register
  logic                   oe_q, oe_d;       // Driver enable register

  // Flow-through reads the current command, pipelined the one before
  assign rst_c = pipe_mode ? s1_q : cmd;    // [RQ6] [RQ11]

  // Next output state
  always_comb begin
    rdv_d = rdv_q;
    dq_d  = dq_q;
    if (asleep_q) begin
      rdv_d = 1'b0;
    end else if (run) begin
      // Writes never turn the drivers on
      rdv_d = rst_c.valid && !rst_c.wr;     // [RQ22]
      dq_d  = mem_q[rst_c.addr];
    end
    oe_d = rdv_d && !g_off && !asleep_q;    // [RQ14]
  end

  // Output registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdv_q <= 1'b0;
      dq_q  <= '0;
      oe_q  <= 1'b0;
    end else begin
      rdv_q <= rdv_d;
      dq_q  <= dq_d;
      oe_q  <= oe_d;
    end
  end

  assign dq_o     = dq_q;
  assign dq_oe_o  = oe_q;
  assign asleep_o = asleep_q;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence rd_issue_pipe;
    run && pipe_mode && cmd.valid && !cmd.wr;
  endsequence

  sequence rd_issue_flow;
    run && !pipe_mode && cmd.valid && !cmd.wr;
  endsequence

  sequence zz_rise;
    $rose(zz_on) && !asleep_q;
  endsequence

  a_gate_holds: assert property (clk_gate_n_i |=> $stable(s1_q) && $stable(dq_q)) // [RQ1]
    else $error("gated edge changed state");
  a_sel_decode: assert property (run && load && !sel |=> !s1_q.valid) // [RQ4]
    else $error("deselected edge made a command");
  a_read_start: assert property (run && load && sel && write_n_i |=>
    s1_q.valid && !s1_q.wr && s1_q.addr == $past(cmd.addr)) // [RQ5]
    else $error("read not latched");
  a_pipe_read: assert property (rd_issue_pipe ##1 (run && pipe_mode) |=> rdv_q) // [RQ6]
    else $error("pipelined read data late");
  a_flow_read: assert property (rd_issue_flow |=> rdv_q) // [RQ11]
    else $error("flow read data late");
  a_write_oe: assert property (run && cmd.wr && !pipe_mode |=> !dq_oe_o) // [RQ22]
    else $error("driver on in write");
  a_g_override: assert property (g_off |=> !dq_oe_o) // [RQ14]
    else $error("output enable ignored");
  a_sleep_enter: assert property (zz_rise ##1 zz_on |=> asleep_q) // [RQ21]
    else $error("sleep not entered in two cycles");
  a_burst_step: assert property (run && !load |=>
    step_q == $past(step_q) + `SSLWP_BURST_1) // [RQ20]
    else $error("burst counter did not advance");

endmodule : sslwp_core
`default_nettype wire

// ---- verif/sslwp_ctrl_model.sv ----
// Bus master model that drives commands and late write data
`timescale 1ns/10ps
`default_nettype none
`include "sslwp_map.svh"
module sslwp_ctrl_model (
  input  wire logic                     clk_sys_i,
  input  wire logic                     flow_i,    // Flow-through data timing
  input  wire logic [1:0]               req_i,     // 0 idle, 1 load, 2 continue
  input  wire logic                     wr_i,      // Write command
  input  wire logic [7:0]               adr_i,     // Word address
  input  wire logic [3:0]               be_n_i,    // Lane strobes, bit 0 is lane a
  input  wire logic [2:0]               off_i,     // Drop one chip select
  input  wire logic [`SSLWP_DQ_W-1:0]   wd_i,      // Write word
  output logic                          adv_o,
  output logic                          wr_n_o,
  output logic [5:0]                    addr_o,
  output logic [1:0]                    bst_o,
  output logic                          sa_n_o,
  output logic                          sh_o,
  output logic                          sb_n_o,
  output logic [3:0]                    lane_n_o,
  output logic [`SSLWP_DQ_W-1:0]        dq_o
);
  logic                   v1, v2; // Data stage valids
  logic [`SSLWP_DQ_W-1:0] d1, d2; // Data stages
  logic                   go;     // Command presented
  assign go       = (req_i != 2'h0);
  assign adv_o    = (req_i == 2'h2);
  assign wr_n_o   = ~wr_i;
  assign addr_o   = adr_i[7:2];
  assign bst_o    = adr_i[1:0];
  assign sa_n_o   = ~go | off_i[0];
  assign sh_o     = go & ~off_i[1];
  assign sb_n_o   = ~go | off_i[2];
  assign lane_n_o = be_n_i;
  // Data trails its write command by one or two edges
  always_ff @(posedge clk_sys_i) begin
    v1 <= go & wr_i;
    d1 <= wd_i;
    v2 <= v1;
    d2 <= d1;
  end
  // Outside its slot the bus shows the inverse word
  assign dq_o = flow_i ? (v1 ? d1 : ~d1) : (v2 ? d2 : ~d2);
endmodule : sslwp_ctrl_model
`default_nettype wire

// ---- verif/sslwp_core_test.sv ----
// Self-checking bench for the late-write SRAM port
`timescale 1ns/10ps
`default_nettype none
module sslwp_core_test;
  typedef struct packed {logic c; logic o; logic [35:0] d;} sslwp_ent_t;
  typedef struct packed {logic w; logic [7:0] a; logic [3:0] b; logic [35:0] d;} sslwp_row_t;
  logic clk_sys_i, rst, gate_n, oe_n, sleep, flow_n, lin_n;
  logic [1:0] req;
  logic wr, advance_load, wr_n, sa_n, sh, sb_n, oe, asl;
  logic [7:0] adr;
  logic [3:0] be_n, ln;
  logic [2:0] off;
  logic [5:0] ha;
  logic [1:0] bs;
  logic [35:0] wd, dqi, dqo;
  sslwp_ent_t cur, e0, e1;
  int failures, tests_run, cyc;
  // Mixed writes, an abort, partial lanes, read-write-read
  sslwp_row_t rows [11] = '{
    '{1, 8'h10, 4'h0, 36'h5_A5A5_A5A5}, '{1, 8'h11, 4'h0, 36'h0_0000_0000},
    '{1, 8'h12, 4'h0, 36'h0_0000_0000}, '{1, 8'h10, 4'hF, 36'h9_9999_9999},
    '{1, 8'h11, 4'hE, 36'hF_FFFF_FFFF}, '{0, 8'h10, 4'hF, 36'h5_A5A5_A5A5},
    '{0, 8'h12, 4'hF, 36'h0_0000_0000}, '{1, 8'h12, 4'h6, 36'hF_FFFF_FFFF},
    '{0, 8'h11, 4'hF, 36'h0_0000_01FF}, '{0, 8'h10, 4'hF, 36'h5_A5A5_A5A5},
    '{0, 8'h12, 4'hF, 36'hF_F800_01FF}};
  sslwp_ctrl_model sslwp_ctrl_model_inst (.clk_sys_i(clk_sys_i), .flow_i(~flow_n),
    .req_i(req), .wr_i(wr), .adr_i(adr), .be_n_i(be_n), .off_i(off), .wd_i(wd),
    .adv_o(advance_load), .wr_n_o(wr_n), .addr_o(ha), .bst_o(bs), .sa_n_o(sa_n), .sh_o(sh),
    .sb_n_o(sb_n), .lane_n_o(ln), .dq_o(dqi));
  sslwp_core sslwp_core_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(rst), .addr_i(ha),
    .burst_start_bits_i(bs), .clk_gate_n_i(gate_n), .advance_load_i(advance_load),
    .write_n_i(wr_n), .chip_sel_lo_a_n_i(sa_n), .chip_sel_hi_i(sh),
    .chip_sel_lo_b_n_i(sb_n), .lane_a_strobe_n_i(ln[0]), .lane_b_strobe_n_i(ln[1]),
    .lane_c_strobe_n_i(ln[2]), .lane_d_strobe_n_i(ln[3]), .out_en_n_i(oe_n),
    .sleep_request_i(sleep), .flow_mode_n_i(flow_n), .linear_order_n_i(lin_n),
    .dq_i(dqi), .dq_o(dqo), .dq_oe_o(oe), .asleep_o(asl));
  initial begin
    clk_sys_i = 0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Compare and count
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Present one command for one edge
  task automatic cmd(input logic [1:0] r, input logic w, input logic [7:0] a,
                     input logic [3:0] b, input logic [35:0] d, input logic c, input logic o);
    @(posedge clk_sys_i);
    req  <= r;
    wr   <= w;
    adr  <= a;
    be_n <= b;
    wd   <= d;
    cur  <= '{c, o, d};
  endtask : cmd
  task automatic idle(input int n);
    repeat (n) cmd(0, 0, 8'h00, 4'hF, 36'h0, 0, 0);
  endtask : idle
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // Output slot tracking per mode
  always @(posedge clk_sys_i) begin
    e1 <= e0;
    e0 <= cur;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      end_of_test;
    end
  end
  always @(negedge clk_sys_i) begin
    if (!rst && (flow_n ? e1.c : e0.c)) begin
      check(36'(oe), 36'(flow_n ? e1.o : e0.o));
      if (flow_n ? e1.o : e0.o) check(dqo, flow_n ? e1.d : e0.d);
    end
  end
  initial begin
    {rst, gate_n, oe_n, sleep, flow_n, lin_n, req, wr, adr, be_n, off, wd} = '0;
    rst = 1;
    flow_n = 1;
    cur = '0;
    cyc = 0;
    failures = 0;
    tests_run = 0;
    repeat (8) @(posedge clk_sys_i);
    rst <= 0;
    #1 check(36'(oe), 36'h0);
    check(36'(asl), 36'h0);
    check(dqo, 36'h0);
    $display("reset test done");
    idle(4);
    for (int p = 0; p < 2; p++) begin
      foreach (rows[i]) cmd(1, rows[i].w, rows[i].a, rows[i].b, rows[i].d, 1, ~rows[i].w);
      idle(4);
      flow_n <= 0;
      idle(4);
      $display("table pass %0d done", p);
    end
    for (int i = 0; i < 3; i++) begin
      cmd(1, 0, 8'h10, 4'hF, 36'h0, 1, 0);
      off <= 3'h1 << i;
    end
    idle(1);
    off <= 0;
    $display("deselect test done");
    for (int i = 0; i < 4; i++) cmd(1, 1, 8'(8'h20 + i), 4'h0, 36'h100 + i, 1, 0);
    for (int m = 0; m < 2; m++) begin
      idle(4);
      cmd(1, 0, 8'h21, 4'hF, 36'h101, 1, 1);
      for (int k = 1; k < 4; k++)
        cmd(2, 0, 8'h21, 4'hF, 36'h100 + (m ? (1 ^ k) : ((1 + k) & 3)), 1, 1);
      idle(1);
      lin_n <= 1;
      $display("burst order %0d done", m);
    end
    oe_n <= 1;
    idle(5);
    cmd(1, 0, 8'h10, 4'hF, 36'h0, 1, 0);
    idle(3);
    oe_n <= 0;
    idle(3);
    // Read, then gated edges must hold its data on the pins
    cmd(1, 0, 8'h10, 4'hF, 36'h5_A5A5_A5A5, 1, 1);
    repeat (3) begin
      cmd(1, 0, 8'h12, 4'hF, 36'h5_A5A5_A5A5, 1, 1);
      gate_n <= 1;
    end
    idle(1);
    gate_n <= 0;
    idle(4);
    sleep <= 1;
    #1 check(36'(oe), 36'h0);
    idle(6);
    #1 check(36'(asl), 36'h1);
    cmd(1, 0, 8'h10, 4'hF, 36'h0, 1, 0);
    idle(2);
    sleep <= 0;
    idle(6);
    #1 check(36'(asl), 36'h0);
    cmd(1, 0, 8'h10, 4'hF, 36'h5_A5A5_A5A5, 1, 1);
    idle(4);
    $display("gate, enable and sleep done");
    end_of_test;
  end
endmodule : sslwp_core_test
`default_nettype wire
